//--- pwl_cfg.svh
// pwl_cfg.svh: register offsets, field positions, reset values and timing figures
// of the window lock detector. assumes a 20 MHz ref_clk and 5-bit register addresses.
`ifndef PWL_CFG_SVH
`define PWL_CFG_SVH

`define PWL_ADDR_W 5
`define PWL_DATA_W 24

`define PWL_ADDR_LD_CFG 5'h07
`define PWL_ADDR_PD_CFG 5'h0b
`define PWL_ADDR_OUT_SEL 5'h0f
`define PWL_ADDR_LD_STAT 5'h12
`define PWL_ADDR_TEST_SEL 5'h13
`define PWL_ADDR_INT_STAT 5'h14
`define PWL_ADDR_INT_MASK 5'h15

`define PWL_LD_CNT_LSB 0
`define PWL_LD_EN_BIT 3
`define PWL_LD_SRC_BIT 6
`define PWL_LD_DIV_LSB 7
`define PWL_LD_SPD_LSB 10
`define PWL_SLIP_THR_LSB 7
`define PWL_OUT_SEL_LSB 0
`define PWL_OUT_SHARE_BIT 6
`define PWL_STAT_OPEN_BIT 0
`define PWL_STAT_LOCK_BIT 1

`define PWL_OUT_SEL_LOCK 5'h01
`define PWL_TEST_OFF 2'h0
`define PWL_TEST_TIMER 2'h1
`define PWL_TEST_LOCK 2'h2
`define PWL_TEST_OPEN 2'h3

`define PWL_LD_CFG_RST 24'h000000
`define PWL_PD_CFG_RST 24'h000000
`define PWL_OUT_SEL_RST 24'h000001
`define PWL_TEST_SEL_RST 2'h0
`define PWL_INT_RST 3'h0

`define PWL_INT_LOCK_GAIN 0
`define PWL_INT_LOCK_LOSS 1
`define PWL_INT_SLIP 2

`define PWL_CLK_MHZ 20
`define PWL_ANALOG_WIN_NS 10
`define PWL_HIT_BASE_LOG2 4

`endif

//--- pwl_lock_detect.sv
// pwl_lock_detect.sv: phase detector window lock detector with its register file.
// assumes ref_edge and fb_edge are one-cycle pulses synchronous to ref_clk,
// and that the serial port outside drives sdo_read_active and sdo_read_bit.
// Function
// - one enable bit gates all lock detection
// - only arrival difference magnitude matters, either first
// - source bit zero selects fixed short window
// - source bit one: window from timer cycles
// - two-bit speed field sets timer clock rate
// - divide codes give 0.5 to 64 cycles
// - window length varies with speed and divide
// - window opens on first arriving edge
// - lock after programmed count of consecutive hits
// - one miss clears lock until count regained
// - lock flag readable as status bit
// - output select puts lock flag on pin
// - sharing bit clear: pin shows read data
// - timer clock routable to test output
// - slip guard boosts gain above phase threshold
`include "pwl_cfg.svh"
`default_nettype none

module pwl_lock_detect #(
  parameter int HIT_W = 12,
  parameter int SLIP_W = 8
) (
  input wire logic ref_clk, // 20 MHz system clock
  input wire logic reset, // async reset, active high
  input wire logic ref_edge, // divided reference arrival, one-cycle pulse
  input wire logic fb_edge, // divided oscillator arrival, one-cycle pulse
  input wire logic [`PWL_ADDR_W-1:0] addr, // register address
  input wire logic [`PWL_DATA_W-1:0] wr_data, // register write data
  input wire logic wr_en, // write strobe
  input wire logic rd_en, // read strobe
  output logic [`PWL_DATA_W-1:0] rd_data, // read data, cycle after rd_en
  input wire logic sdo_read_active, // serial port read in progress
  input wire logic sdo_read_bit, // serial port read data bit
  output logic lock_or_serial_out_pin, // shared lock / serial data pin
  output logic general_test_output, // test observation pin
  output logic lock_flag, // lock detect flag
  output logic slip_guard, // raise phase detector gain
  output logic irq // level interrupt
);

  localparam int ANALOG_CYC_RAW = (`PWL_ANALOG_WIN_NS * `PWL_CLK_MHZ + 999) / 1000;
  localparam int ANALOG_CYC = (ANALOG_CYC_RAW < 1) ? 1 : ANALOG_CYC_RAW;

  // registers
  logic [`PWL_DATA_W-1:0] ld_cfg_q;
  logic [`PWL_DATA_W-1:0] pd_cfg_q;
  logic [`PWL_DATA_W-1:0] out_sel_q;
  logic [1:0] test_sel_q;
  logic [2:0] int_stat_q;
  logic [2:0] int_stat_d;
  logic [2:0] int_mask_q;
  logic [`PWL_DATA_W-1:0] rd_data_q;

  // window tracking
  pwl_pkg::pwl_win_state_type state_q;
  pwl_pkg::pwl_win_state_type state_d;
  logic hit;
  logic miss;
  logic win_start;
  logic win_abort;
  logic win_expired;
  logic timer_clk;
  logic [HIT_W-1:0] hit_cnt_q;
  logic [HIT_W-1:0] hit_target;
  logic lock_q;
  logic lock_prev_q;

  // slip guard tracking
  logic slip_pend_q;
  logic slip_ref_first_q;
  logic [SLIP_W-1:0] slip_cnt_q;
  logic [SLIP_W-1:0] slip_thr;
  logic slip_q;
  logic slip_prev_q;

  // pin outputs
  logic pin_q;
  logic gto_q;

  // decoded fields
  logic ld_enable;
  logic ld_digital;
  logic [2:0] ld_cnt_code;
  logic [2:0] ld_div;
  logic [1:0] ld_speed;
  logic [1:0] slip_code;
  logic [4:0] out_sel;
  logic out_share_off;
  logic clear_stat;

  assign ld_enable = ld_cfg_q[`PWL_LD_EN_BIT];
  assign ld_digital = ld_cfg_q[`PWL_LD_SRC_BIT];
  assign ld_cnt_code = ld_cfg_q[`PWL_LD_CNT_LSB +: 3];
  assign ld_div = ld_cfg_q[`PWL_LD_DIV_LSB +: 3];
  assign ld_speed = ld_cfg_q[`PWL_LD_SPD_LSB +: 2];
  assign slip_code = pd_cfg_q[`PWL_SLIP_THR_LSB +: 2];
  assign out_sel = out_sel_q[`PWL_OUT_SEL_LSB +: 5];
  assign out_share_off = out_sel_q[`PWL_OUT_SHARE_BIT];
  assign clear_stat = wr_en && (addr == `PWL_ADDR_INT_STAT);

  // consecutive hits needed: code 0 is 16, code 7 is 2048
  assign hit_target = HIT_W'(1) << ({1'b0, ld_cnt_code} + 4'(`PWL_HIT_BASE_LOG2));

  // register writes
  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
      ld_cfg_q <= `PWL_LD_CFG_RST;
    else if (wr_en && addr == `PWL_ADDR_LD_CFG)
      ld_cfg_q <= wr_data;

  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
      pd_cfg_q <= `PWL_PD_CFG_RST;
    else if (wr_en && addr == `PWL_ADDR_PD_CFG)
      pd_cfg_q <= wr_data;

  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
      out_sel_q <= `PWL_OUT_SEL_RST;
    else if (wr_en && addr == `PWL_ADDR_OUT_SEL)
      out_sel_q <= wr_data;

  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
      test_sel_q <= `PWL_TEST_SEL_RST;
    else if (wr_en && addr == `PWL_ADDR_TEST_SEL)
      test_sel_q <= wr_data[1:0];

  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
      int_mask_q <= `PWL_INT_RST;
    else if (wr_en && addr == `PWL_ADDR_INT_MASK)
      int_mask_q <= wr_data[2:0];

  // a new event in the clearing cycle survives the write of one
  always_comb
  begin
    int_stat_d = int_stat_q & ~(clear_stat ? wr_data[2:0] : 3'h0);
    int_stat_d[`PWL_INT_LOCK_GAIN] = int_stat_d[`PWL_INT_LOCK_GAIN] | (lock_q & ~lock_prev_q);
    int_stat_d[`PWL_INT_LOCK_LOSS] = int_stat_d[`PWL_INT_LOCK_LOSS] | (~lock_q & lock_prev_q);
    int_stat_d[`PWL_INT_SLIP] = int_stat_d[`PWL_INT_SLIP] | (slip_q & ~slip_prev_q);
  end

  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
      int_stat_q <= `PWL_INT_RST;
    else
      int_stat_q <= int_stat_d;

  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
    begin
      lock_prev_q <= 1'b0;
      slip_prev_q <= 1'b0;
    end
    else
    begin
      lock_prev_q <= lock_q;
      slip_prev_q <= slip_q;
    end

  assign irq = |(int_stat_q & int_mask_q);

  // register reads, answered one cycle later; unmapped reads return zero
  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
      rd_data_q <= '0;
    else if (rd_en)
    begin
      case (addr)
        `PWL_ADDR_LD_CFG: rd_data_q <= ld_cfg_q;
        `PWL_ADDR_PD_CFG: rd_data_q <= pd_cfg_q;
        `PWL_ADDR_OUT_SEL: rd_data_q <= out_sel_q;
        `PWL_ADDR_LD_STAT:
        begin
          rd_data_q <= '0;
          rd_data_q[`PWL_STAT_LOCK_BIT] <= lock_q;
          rd_data_q[`PWL_STAT_OPEN_BIT] <= (state_q != pwl_pkg::PWL_IDLE);
        end
        `PWL_ADDR_TEST_SEL: rd_data_q <= {22'h000000, test_sel_q};
        `PWL_ADDR_INT_STAT: rd_data_q <= {21'h000000, int_stat_q};
        `PWL_ADDR_INT_MASK: rd_data_q <= {21'h000000, int_mask_q};
        default: rd_data_q <= '0;
      endcase
    end
    else
      rd_data_q <= '0;

  assign rd_data = rd_data_q;

  // window timer: short fixed window or timer based window
  pwl_window_timer #(
    .SPD_W(2),
    .DIV_W(3),
    .ANALOG_CYC(ANALOG_CYC)
  ) u_timer (
    .ref_clk(ref_clk),
    .reset(reset),
    .digital_sel(ld_digital),
    .speed(ld_speed),
    .divide(ld_div),
    .start(win_start),
    .abort(win_abort),
    .timer_clk(timer_clk),
    .expired(win_expired)
  );

  // window state: either edge may open it, the other must follow inside it
  always_comb
  begin
    state_d = state_q;
    hit = 1'b0;
    miss = 1'b0;
    win_start = 1'b0;
    win_abort = 1'b0;
    if (!ld_enable)
    begin
      state_d = pwl_pkg::PWL_IDLE;
      win_abort = 1'b1;
    end
    else
    begin
      case (state_q)
        pwl_pkg::PWL_IDLE:
        begin
          if (ref_edge && fb_edge)
            hit = 1'b1;
          else if (ref_edge)
          begin
            state_d = pwl_pkg::PWL_WAIT_FB;
            win_start = 1'b1;
          end
          else if (fb_edge)
          begin
            state_d = pwl_pkg::PWL_WAIT_REF;
            win_start = 1'b1;
          end
        end
        pwl_pkg::PWL_WAIT_FB:
        begin
          if (fb_edge)
          begin
            hit = 1'b1;
            state_d = pwl_pkg::PWL_IDLE;
            win_abort = 1'b1;
          end
          else if (ref_edge)
          begin
            miss = 1'b1; // second reference with no feedback between
            win_start = 1'b1;
          end
          else if (win_expired)
          begin
            miss = 1'b1;
            state_d = pwl_pkg::PWL_IDLE;
          end
        end
        pwl_pkg::PWL_WAIT_REF:
        begin
          if (ref_edge)
          begin
            hit = 1'b1;
            state_d = pwl_pkg::PWL_IDLE;
            win_abort = 1'b1;
          end
          else if (fb_edge)
          begin
            miss = 1'b1;
            win_start = 1'b1;
          end
          else if (win_expired)
          begin
            miss = 1'b1;
            state_d = pwl_pkg::PWL_IDLE;
          end
        end
        default:
        begin
          state_d = pwl_pkg::PWL_IDLE;
          win_abort = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
      state_q <= pwl_pkg::PWL_IDLE;
    else
      state_q <= state_d;

  // consecutive hit counter saturates so a long lock never wraps
  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
      hit_cnt_q <= '0;
    else if (!ld_enable || miss)
      hit_cnt_q <= '0;
    else if (hit && hit_cnt_q < hit_target)
      hit_cnt_q <= hit_cnt_q + HIT_W'(1);
    else if (hit_cnt_q > hit_target)
      hit_cnt_q <= hit_target;

  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
      lock_q <= 1'b0;
    else if (!ld_enable || miss)
      lock_q <= 1'b0;
    else if (hit && hit_cnt_q == hit_target - HIT_W'(1))
      lock_q <= 1'b1;

  assign lock_flag = lock_q;

  // slip guard measures phase error apart from the lock enable, since it is
  // a phase detector feature; threshold codes give 2, 4, 8, 16 cycles
  assign slip_thr = SLIP_W'(2) << slip_code;

  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
    begin
      slip_pend_q <= 1'b0;
      slip_ref_first_q <= 1'b0;
      slip_cnt_q <= '0;
    end
    else if (!slip_pend_q)
    begin
      slip_pend_q <= ref_edge ^ fb_edge;
      slip_ref_first_q <= ref_edge;
      slip_cnt_q <= '0;
    end
    else if ((slip_ref_first_q && fb_edge) || (!slip_ref_first_q && ref_edge))
      slip_pend_q <= 1'b0;
    else if (slip_cnt_q != {SLIP_W{1'b1}})
      slip_cnt_q <= slip_cnt_q + SLIP_W'(1);

  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
      slip_q <= 1'b0;
    else
      slip_q <= slip_pend_q && (slip_cnt_q >= slip_thr);

  assign slip_guard = slip_q;

  // shared pin: lock flag, or serial read data while a read runs
  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
      pin_q <= 1'b0;
    else if (out_sel == `PWL_OUT_SEL_LOCK)
    begin
      if (!out_share_off && sdo_read_active)
        pin_q <= sdo_read_bit;
      else
        pin_q <= lock_q;
    end
    else
      pin_q <= sdo_read_active ? sdo_read_bit : 1'b0;

  assign lock_or_serial_out_pin = pin_q;

  // test output lags the timer clock by one cycle, acceptable for observation
  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
      gto_q <= 1'b0;
    else
    begin
      case (test_sel_q)
        `PWL_TEST_TIMER: gto_q <= timer_clk;
        `PWL_TEST_LOCK: gto_q <= lock_q;
        `PWL_TEST_OPEN: gto_q <= (state_q != pwl_pkg::PWL_IDLE);
        default: gto_q <= 1'b0;
      endcase
    end

  assign general_test_output = gto_q;

endmodule

`default_nettype wire

//--- pwl_lock_detect_monitor.sv
// pwl_lock_detect_monitor.sv: port assertions for the window lock detector.
// assumes it is bound onto pwl_lock_detect and sees only its ports.
`include "pwl_cfg.svh"
`default_nettype none

module pwl_mon (
  input wire logic ref_clk, // clock
  input wire logic reset, // async reset
  input wire logic ref_edge, // reference arrival
  input wire logic fb_edge, // feedback arrival
  input wire logic [`PWL_ADDR_W-1:0] addr, // address
  input wire logic [`PWL_DATA_W-1:0] wr_data, // write data
  input wire logic wr_en, // write strobe
  input wire logic rd_en, // read strobe
  input wire logic [`PWL_DATA_W-1:0] rd_data, // read data
  input wire logic sdo_read_active, // serial read running
  input wire logic sdo_read_bit, // serial data bit
  input wire logic lock_or_serial_out_pin, // shared pin
  input wire logic general_test_output, // test pin
  input wire logic lock_flag, // lock flag
  input wire logic irq // interrupt
);
  logic en_q;
  logic pin_ok_q;
  logic msk_q;
  logic [1:0] tst_q;

  // shadow of the few register fields the assertions depend on
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      en_q <= 1'b0;
      pin_ok_q <= 1'b1;
      msk_q <= 1'b0;
      tst_q <= 2'h0;
    end
    else if (wr_en)
    begin
      if (addr == `PWL_ADDR_LD_CFG)
        en_q <= wr_data[`PWL_LD_EN_BIT];
      if (addr == `PWL_ADDR_OUT_SEL)
        pin_ok_q <= wr_data[6:0] == 7'h01;
      if (addr == `PWL_ADDR_INT_MASK)
        msk_q <= wr_data[0];
      if (addr == `PWL_ADDR_TEST_SEL)
        tst_q <= wr_data[1:0];
    end
  end

  default clocking mon_cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  // stable-source pairs avoid guessing a one-cycle output latency
  sequence stat_rd;
    rd_en && addr == `PWL_ADDR_LD_STAT ##1 $stable(lock_flag);
  endsequence
  sequence pin_quiet;
    pin_ok_q && !sdo_read_active ##1 pin_ok_q && !sdo_read_active && $stable(lock_flag);
  endsequence
  sequence pin_read;
    pin_ok_q && sdo_read_active ##1 pin_ok_q && sdo_read_active && $stable(sdo_read_bit);
  endsequence

  stat_read_a: assert property (stat_rd |-> rd_data[`PWL_STAT_LOCK_BIT] == lock_flag)
    else $error("status lock bit differs from lock flag");
  rd_idle_a: assert property (!$past(rd_en) |-> rd_data == '0)
    else $error("read data not zero outside read cycle");
  lock_cause_a: assert property ($rose(lock_flag) |-> $past(ref_edge || fb_edge))
    else $error("lock rose without an arrival");
  lock_off_a: assert property (!en_q && !$past(en_q) && !$past(en_q, 2) |-> !lock_flag)
    else $error("lock flag high while detection disabled");
  pin_lock_a: assert property (pin_quiet |-> lock_or_serial_out_pin == lock_flag)
    else $error("pin does not show lock flag");
  pin_read_a: assert property (pin_read |-> lock_or_serial_out_pin == sdo_read_bit)
    else $error("pin does not show serial read data");
  test_lock_a: assert property (tst_q == `PWL_TEST_LOCK ##1
    tst_q == `PWL_TEST_LOCK && $stable(lock_flag) |-> general_test_output == lock_flag)
    else $error("test output does not follow lock flag");
  irq_gain_a: assert property ($rose(lock_flag) && msk_q ##1 msk_q |-> irq)
    else $error("no interrupt after unmasked lock gain");
endmodule

bind pwl_lock_detect pwl_mon mon_u (
  .ref_clk, .reset, .ref_edge, .fb_edge, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
  .sdo_read_active, .sdo_read_bit, .lock_or_serial_out_pin, .general_test_output,
  .lock_flag, .irq
);

`default_nettype wire

//--- pwl_lock_detect_tb.sv
// pwl_lock_detect_tb.sv: register driven bench for the window lock detector.
// assumes the arrival model and the bound port checker.
`include "pwl_cfg.svh"
`default_nettype none

module pwl_lock_detect_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [4:0] addr = 5'h00;
  logic [23:0] wr_data = 24'h000000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic sdo_read_active = 1'b0;
  logic sdo_read_bit = 1'b0;
  logic run = 1'b0;
  logic fb_first = 1'b0;
  logic [5:0] lag = 6'h01;
  logic [5:0] period = 6'h08;
  logic ref_edge, fb_edge, pin, gto, lock_flag, slip, irq, prev;
  logic [23:0] rd_data;
  int bad_count = 0;
  int checks_done = 0;
  int n;

  always #25 ref_clk = ~ref_clk;

  pwl_pd_model pd_u (.ref_clk, .reset, .run, .fb_first, .lag, .period, .ref_edge, .fb_edge);
  pwl_lock_detect dut_u (.ref_clk, .reset, .ref_edge, .fb_edge, .addr, .wr_data, .wr_en,
    .rd_en, .rd_data, .sdo_read_active, .sdo_read_bit, .lock_or_serial_out_pin(pin),
    .general_test_output(gto), .lock_flag, .slip_guard(slip), .irq);

  task automatic tally_and_finish();
    if (bad_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [23:0] d);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [23:0] m, input logic [23:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    @(negedge ref_clk);
    chk(rd_data & m, e);
  endtask

  task automatic pd(input logic f, input logic [5:0] l, input logic [5:0] p);
    @(posedge ref_clk);
    run <= 1'b1;
    fb_first <= f;
    lag <= l;
    period <= p;
  endtask

  task automatic wt(input int c);
    repeat (c) @(negedge ref_clk);
  endtask

  initial
  begin
    #1000000;
    bad_count++;
    tally_and_finish();
  end

  initial
  begin
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    rd(`PWL_ADDR_LD_CFG, 24'hffffff, `PWL_LD_CFG_RST);
    rd(`PWL_ADDR_OUT_SEL, 24'hffffff, `PWL_OUT_SEL_RST);
    rd(5'h1f, 24'hffffff, 24'h000000);
    pd(1'b0, 6'h01, 6'h08);
    wt(160);
    rd(`PWL_ADDR_LD_STAT, 24'h000002, 24'h000000);
    wr(`PWL_ADDR_INT_STAT, 24'h000007);
    wr(`PWL_ADDR_INT_MASK, 24'h000001);
    wr(`PWL_ADDR_LD_CFG, 24'h000008);
    wt(80);
    chk(24'(lock_flag), 24'h0);
    wt(80);
    chk(24'(lock_flag), 24'h1);
    chk(24'(irq), 24'h1);
    chk(24'(pin), 24'h1);
    rd(`PWL_ADDR_LD_STAT, 24'h000002, 24'h000002);
    @(posedge ref_clk);
    sdo_read_active <= 1'b1;
    wt(3);
    chk(24'(pin), 24'h0);
    @(posedge ref_clk);
    sdo_read_active <= 1'b0;
    wt(3);
    chk(24'(pin), 24'h1);
    wr(`PWL_ADDR_INT_MASK, 24'h000000);
    wt(2);
    chk(24'(irq), 24'h0);
    wr(`PWL_ADDR_INT_MASK, 24'h000001);
    wr(`PWL_ADDR_INT_STAT, 24'h000001);
    wt(2);
    chk(24'(irq), 24'h0);
    pd(1'b1, 6'h01, 6'h08);
    wt(160);
    chk(24'(lock_flag), 24'h1);
    pd(1'b0, 6'h03, 6'h08);
    wt(24);
    chk(24'(lock_flag), 24'h0);
    rd(`PWL_ADDR_INT_STAT, 24'h000002, 24'h000002);
    pd(1'b0, 6'h01, 6'h08);
    wt(80);
    chk(24'(lock_flag), 24'h0);
    wt(80);
    chk(24'(lock_flag), 24'h1);
    // timer window cases: speed, divide, expected lock with arrivals 5 cycles apart
    pd(1'b0, 6'h05, 6'h20);
    wr(`PWL_ADDR_LD_CFG, 24'h0001c8);
    wt(640);
    chk(24'(lock_flag), 24'h1);
    wr(`PWL_ADDR_LD_CFG, 24'h0000c8);
    wt(640);
    chk(24'(lock_flag), 24'h0);
    wr(`PWL_ADDR_LD_CFG, 24'h000cc8);
    wt(640);
    chk(24'(lock_flag), 24'h1);
    wr(`PWL_ADDR_TEST_SEL, 24'(`PWL_TEST_TIMER));
    // let the registered test pin pick up the timer before counting its toggles
    wt(2);
    n = 0;
    prev = gto;
    repeat (64)
    begin
      @(negedge ref_clk);
      n += int'(gto != prev);
      prev = gto;
    end
    // slowest speed: the timer clock toggles every 8 cycles
    chk(24'(n), 24'h8);
    wr(`PWL_ADDR_TEST_SEL, 24'(`PWL_TEST_LOCK));
    for (int c = 0; c < 4; c++)
    begin
      wr(`PWL_ADDR_PD_CFG, 24'(c) << `PWL_SLIP_THR_LSB);
      wt(32);
      n = 0;
      repeat (64)
      begin
        @(negedge ref_clk);
        n += int'(slip);
      end
      chk(24'(n != 0), 24'(5 >= (2 << c)));
    end
    wr(`PWL_ADDR_LD_CFG, 24'h000000);
    wt(4);
    chk(24'(lock_flag), 24'h0);
    tally_and_finish();
  end
endmodule

`default_nettype wire

//--- pwl_pd_model.sv
// pwl_pd_model.sv: divided reference and feedback arrival source.
// assumes the bench changes its controls just after a rising edge.
`default_nettype none

module pwl_pd_model (
  input wire logic ref_clk, // clock
  input wire logic reset, // async reset
  input wire logic run, // produce arrivals
  input wire logic fb_first, // feedback leads
  input wire logic [5:0] lag, // spacing of the two arrivals
  input wire logic [5:0] period, // comparison period in cycles
  output logic ref_edge, // reference arrival pulse
  output logic fb_edge // feedback arrival pulse
);
  logic [5:0] cnt_q;
  logic lead;
  logic trail;

  // period of 8 cycles or more keeps the rate far below the short window limit
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      cnt_q <= 6'h00;
    else
      cnt_q <= (cnt_q + 6'h01 >= period) ? 6'h00 : cnt_q + 6'h01;
  end
  // lag stays below one period so every window closes before the next
  assign lead = run && cnt_q == 6'h00;
  assign trail = run && cnt_q == lag;
  assign ref_edge = fb_first ? trail : lead;
  assign fb_edge = fb_first ? lead : trail;
endmodule

`default_nettype wire

//--- pwl_pkg.sv
// pwl_pkg.sv: types shared by the window lock detector files.
// assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package pwl_pkg;

  typedef enum logic [1:0] {
    PWL_IDLE = 2'b00,
    PWL_WAIT_FB = 2'b01,
    PWL_WAIT_REF = 2'b10
  } pwl_win_state_type;

endpackage

`default_nettype wire

//--- pwl_window_timer.sv
// pwl_window_timer.sv: window timer clock generator and one-shot window counter.
// assumes start and abort are one-cycle pulses on ref_clk.
`include "pwl_cfg.svh"
`default_nettype none

module pwl_window_timer #(
  parameter int SPD_W = 2,
  parameter int DIV_W = 3,
  parameter int ANALOG_CYC = 1
) (
  input wire logic ref_clk, // system clock
  input wire logic reset, // async reset, active high
  input wire logic digital_sel, // 1: timer based window, 0: fixed short window
  input wire logic [SPD_W-1:0] speed, // timer clock speed code, 0 fastest
  input wire logic [DIV_W-1:0] divide, // window length code in timer half periods
  input wire logic start, // open a window
  input wire logic abort, // close the window early
  output logic timer_clk, // window timer clock level
  output logic expired // window ran out, one-cycle pulse
);

  logic [7:0] pre_q;
  logic [7:0] pre_lim;
  logic half_tick;
  logic tclk_q;
  logic run_q;
  logic [8:0] left_q;
  logic dec;

  // each speed step halves the timer clock
  assign pre_lim = 8'((9'h001 << speed) - 9'h001);
  assign half_tick = (pre_q == pre_lim);
  assign dec = run_q && (digital_sel ? half_tick : 1'b1);
  // the caller ranks edges above expiry, so start and abort stay out of this term
  // and no combinational loop forms through the window state logic
  assign expired = dec && (left_q == 9'h001);
  assign timer_clk = tclk_q;

  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
      pre_q <= 8'h00;
    else if (half_tick)
      pre_q <= 8'h00;
    else
      pre_q <= pre_q + 8'h01;

  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
      tclk_q <= 1'b0;
    else if (half_tick)
      tclk_q <= !tclk_q;

  // code 0 is half a timer cycle, each step doubles it
  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
    begin
      run_q <= 1'b0;
      left_q <= 9'h000;
    end
    else if (start)
    begin
      run_q <= 1'b1;
      left_q <= digital_sel ? (9'h001 << divide) : 9'(ANALOG_CYC);
    end
    else if (abort || expired)
      run_q <= 1'b0;
    else if (dec)
      left_q <= left_q - 9'h001;

endmodule

`default_nettype wire
